// ===== rtl/picl_map.vh
// Constants for the pin interrupt capture block.
// Assumes inclusion by the capture module only.
`ifndef PICL_MAP_VH
`define PICL_MAP_VH
// Edge flag register bit positions, width and reset value
`define PICL_EF_RISE_A    0
`define PICL_EF_RISE_B    1
`define PICL_EF_FALL_A    2
`define PICL_EF_CAPTURE   3
`define PICL_EF_FALL_B    4
`define PICL_EF_FALL_C    5
`define PICL_EF_MEAS_RISE 6
`define PICL_EF_LEVEL     7
`define PICL_EF_WIDTH     8
`define PICL_EF_RESET     8'h00
// Timer edge select codes (hi,lo)
`define PICL_SEL_NONE     2'h0
`define PICL_SEL_RISE     2'h1
`define PICL_SEL_FALL     2'h2
`define PICL_SEL_BOTH     2'h3
// Pin positions in the synchroniser vector
`define PICL_PIN_RISE_A   0
`define PICL_PIN_RISE_B   1
`define PICL_PIN_FALL_A   2
`define PICL_PIN_FALL_B   3
`define PICL_PIN_FALL_C   4
`define PICL_PIN_MEAS     5
`define PICL_PIN_LEVEL_N  6
`define PICL_PIN_NMI_N    7
// Synchroniser reset level, pins read as idle high
`define PICL_SYNC_RESET   8'hff
`endif

// ===== rtl/picl_capture.v
// Pin interrupt capture: edge flags, level request, non-maskable and abort inputs,
// pulse-width timer capture. Pins are asynchronous; core side is on i_clk_sys.
//
// Notes on behaviour
// [R1] A low-to-high change on a rising-edge input sets its flag; high-to-low does nothing.
// [R2] A high-to-low change on a falling-edge input sets its flag; low-to-high does nothing.
// [R3] An interrupt request is raised only for a flagged, enabled source while the disable flag is 0.
// [R4] The measurement pin is a member of both the rising and the falling edge groups.
// [R5] The level request pin is shared with general I/O and bus control bit 6 picks its use.
// [R6] With bus control bit 6 set, flag bit 7 is held at 1 while the level request pin is low.
// [R7] With enable bit 7 set, the level request interrupts for as long as the pin stays low.
// [R8] With bus control bit 6 set, every falling edge on the shared pin gives a non-maskable request.
// [R9] With bus control bit 5 set, the abort function of that pin is enabled, alongside the other if both set.
// [R10] On each measurement edge chosen by timer control bits 2 and 3, the timer count is copied to its latch.
// [R11] Each such capture also sets flag bit 3.
// [R12] A captured edge flag stays set until software clears it by writing a 1 to its clear bit.
`timescale 1ns/1ps
`include "picl_map.vh"
module picl_capture #(
  parameter TIMER_W = 16
) (
  // Clock and reset
  input  wire               i_clk_sys,
  input  wire               i_rst,
  // Interrupt pins (asynchronous)
  input  wire               i_rise_edge_input_a,
  input  wire               i_rise_edge_input_b,
  input  wire               i_fall_edge_input_a,
  input  wire               i_fall_edge_input_b,
  input  wire               i_fall_edge_input_c,
  input  wire               i_measure_pin,
  input  wire               i_level_req_n,
  input  wire               i_nmi_abort_n,
  // Configuration
  input  wire               i_bus_ctrl_request_select,
  input  wire               i_bus_ctrl_fault_enable,
  input  wire               i_timer_ctrl_edge_sel_lo,
  input  wire               i_timer_ctrl_edge_sel_hi,
  input  wire [7:0]         i_interrupt_enable_regs,
  input  wire [7:0]         i_flag_clear,
  input  wire               i_core_irq_disable,
  input  wire [TIMER_W-1:0] i_measure_timer_count,
  // Core side
  output reg  [7:0]         o_interrupt_flag_regs,
  output reg                o_irq,
  output reg                o_nmi,
  output reg                o_abort,
  output reg                o_level_gpio_in,
  output reg                o_nmi_abort_gpio_in,
  output reg  [TIMER_W-1:0] o_measure_timer_latch
);

  // ****************************************
  // Pin synchronisers and edge history
  // ****************************************
  // Bits: 0 rise_a,1 rise_b,2 fall_a,3 fall_b,4 fall_c,5 meas,6 level_n,7 nmi_n
  wire [7:0] pins = {i_nmi_abort_n, i_level_req_n, i_measure_pin, i_fall_edge_input_c,
                     i_fall_edge_input_b, i_fall_edge_input_a, i_rise_edge_input_b,
                     i_rise_edge_input_a};
  reg  [7:0] sync1_reg;
  reg  [7:0] sync2_reg;
  reg  [7:0] prev_reg;

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      sync1_reg <= `PICL_SYNC_RESET;
      sync2_reg <= `PICL_SYNC_RESET;
      prev_reg  <= `PICL_SYNC_RESET;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // ****************************************
  // Helper functions
  // ****************************************
  // Bits high in the first vector and low in the second
  function [7:0] edge_up;
    input [7:0] now_val;
    input [7:0] old_val;
    begin
      edge_up = now_val & ~old_val;
    end
  endfunction

  // True when any flag meets its enable bit
  function any_enabled;
    input [7:0] flag_val;
    input [7:0] enable_val;
    begin
      any_enabled = |(flag_val & enable_val);
    end
  endfunction

  // ****************************************
  // One-shots
  // ****************************************
  // One pulse per transition; a pin pulse under one clock may be lost
  wire [7:0] rise_pulse;
  wire [7:0] fall_pulse;

  assign rise_pulse = edge_up(sync2_reg, prev_reg); // R1
  assign fall_pulse = edge_up(prev_reg, sync2_reg); // R2

  // Named pulses per source
  wire       rise_a_pulse;
  wire       rise_b_pulse;
  wire       fall_a_pulse;
  wire       fall_b_pulse;
  wire       fall_c_pulse;
  wire       meas_rise;
  wire       meas_fall;
  wire       nmi_fall;

  assign rise_a_pulse = rise_pulse[`PICL_PIN_RISE_A];
  assign rise_b_pulse = rise_pulse[`PICL_PIN_RISE_B];
  assign fall_a_pulse = fall_pulse[`PICL_PIN_FALL_A];
  assign fall_b_pulse = fall_pulse[`PICL_PIN_FALL_B];
  assign fall_c_pulse = fall_pulse[`PICL_PIN_FALL_C];
  assign meas_rise    = rise_pulse[`PICL_PIN_MEAS]; // R4
  assign meas_fall    = fall_pulse[`PICL_PIN_MEAS]; // R4
  assign nmi_fall     = fall_pulse[`PICL_PIN_NMI_N];

  // ****************************************
  // Edge flags
  // ****************************************
  wire [1:0] edge_sel;
  wire       capture;
  wire       level_mode;
  wire       level_low;

  assign edge_sel   = {i_timer_ctrl_edge_sel_hi, i_timer_ctrl_edge_sel_lo};
  assign capture    = (meas_rise && edge_sel[0]) || (meas_fall && edge_sel[1]); // R10
  assign level_mode = i_bus_ctrl_request_select; // R5
  assign level_low  = level_mode && !sync2_reg[`PICL_PIN_LEVEL_N];

  reg  [7:0] flag_set;
  reg  [7:0] flag_next;

  always @* begin
    flag_set = 8'h00;
    flag_set[`PICL_EF_RISE_A]    = rise_a_pulse; // R1
    flag_set[`PICL_EF_RISE_B]    = rise_b_pulse; // R1
    flag_set[`PICL_EF_FALL_A]    = fall_a_pulse; // R2
    flag_set[`PICL_EF_FALL_B]    = fall_b_pulse; // R2
    flag_set[`PICL_EF_FALL_C]    = fall_c_pulse; // R2
    flag_set[`PICL_EF_MEAS_RISE] = meas_rise; // R4
    // Measurement falling edge is in the falling group as well
    flag_set[`PICL_EF_CAPTURE]   = capture | meas_fall; // R4 R11

    // Set wins over a clear in the same cycle
    flag_next = (o_interrupt_flag_regs & ~i_flag_clear) | flag_set; // R12
    // Level bit follows the pin, not sticky
    flag_next[`PICL_EF_LEVEL] = level_low; // R6
  end

  // ****************************************
  // Flag register
  // ****************************************
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_interrupt_flag_regs <= `PICL_EF_RESET;
    end else begin
      o_interrupt_flag_regs <= flag_next; // R12
    end
  end

  // ****************************************
  // Core requests
  // ****************************************
  reg        irq_next;
  reg        nmi_next;
  reg        abort_next;

  always @* begin
    irq_next   = 1'b0;
    nmi_next   = 1'b0;
    abort_next = 1'b0;
    // Disable flag gates the maskable request only
    if (!i_core_irq_disable) begin
      irq_next = any_enabled(flag_next, i_interrupt_enable_regs); // R3 R7
    end
    if (i_bus_ctrl_request_select) begin
      nmi_next = nmi_fall; // R8
    end
    // Abort is a level request; both may be on at once
    if (i_bus_ctrl_fault_enable) begin
      abort_next = !sync2_reg[`PICL_PIN_NMI_N]; // R9
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_irq   <= 1'b0;
      o_nmi   <= 1'b0;
      o_abort <= 1'b0;
    end else begin
      o_irq   <= irq_next;
      o_nmi   <= nmi_next;
      o_abort <= abort_next;
    end
  end

  // ****************************************
  // Pin readback
  // ****************************************
  // Plain synchronised levels for general I/O reads
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_level_gpio_in     <= 1'b1;
      o_nmi_abort_gpio_in <= 1'b1;
    end else begin
      o_level_gpio_in     <= sync2_reg[`PICL_PIN_LEVEL_N]; // R5
      o_nmi_abort_gpio_in <= sync2_reg[`PICL_PIN_NMI_N];
    end
  end

  // ****************************************
  // Timer capture
  // ****************************************
  // Latch keeps its value between selected edges
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_measure_timer_latch <= {TIMER_W{1'b0}};
    end else if (capture) begin
      o_measure_timer_latch <= i_measure_timer_count; // R10
    end
  end

endmodule

// ===== dv/picl_capture_assertions.sv
// Checker on the capture block ports.
// Assumes a bind onto every capture instance.
`timescale 1ns/1ps
module picl_chk #(parameter TIMER_W = 16) (
  input wire i_clk_sys, i_rst, i_rise_edge_input_a, i_fall_edge_input_b, i_measure_pin, i_level_req_n,
  input wire i_nmi_abort_n, i_bus_ctrl_request_select, i_bus_ctrl_fault_enable, i_timer_ctrl_edge_sel_lo,
  input wire i_core_irq_disable, o_irq, o_nmi, o_abort,
  input wire [7:0] i_interrupt_enable_regs, i_flag_clear, o_interrupt_flag_regs,
  input wire [TIMER_W-1:0] i_measure_timer_count, o_measure_timer_latch);
  wire [7:0] f = o_interrupt_flag_regs;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_rise_flag: assert property ($rose(i_rise_edge_input_a) |-> ##3 f[0]) else $error("rise");
  a_fall_flag: assert property ($fell(i_fall_edge_input_b) |-> ##3 f[4]) else $error("fall");
  a_irq_gate: assert property (o_irq == (!$past(i_core_irq_disable) && |(f & $past(i_interrupt_enable_regs))))
    else $error("irq");
  a_level_flag: assert property ((i_bus_ctrl_request_select && !i_level_req_n)[*5] |-> f[7])
    else $error("level");
  a_nmi_pulse: assert property ($fell(i_nmi_abort_n) && i_bus_ctrl_request_select |-> ##3 o_nmi ##1 !o_nmi)
    else $error("nmi");
  a_abort_lvl: assert property ((i_bus_ctrl_fault_enable && !i_nmi_abort_n)[*5] |-> o_abort)
    else $error("abort");
  a_width_cap: assert property ($rose(i_measure_pin) && i_timer_ctrl_edge_sel_lo |-> ##3 f[3] &&
    o_measure_timer_latch == $past(i_measure_timer_count)) else $error("capture");
  a_flag_hold: assert property (f[0] && !i_flag_clear[0] |=> f[0]) else $error("hold");
endmodule
bind picl_capture picl_chk #(.TIMER_W(TIMER_W)) u_chk (.*);

// ===== dv/picl_pin_src.sv
// Interrupt source model driving the eight pins.
// Assumes callers hold each level several cycles.
`timescale 1ns/1ps
module picl_pin_src (input wire i_clk_sys, output logic [7:0] o_pins = 8'hdc);
  task drive(input logic [7:0] v); begin @(posedge i_clk_sys); #1 o_pins = v; end endtask
endmodule

// ===== dv/picl_capture_bench.sv
// Self-checking bench for the capture block.
// Assumes the pin source model and bound checker.
`timescale 1ns/1ps
module picl_capture_bench;
  logic clk = 0, rst = 1, mon = 0, sel_req = 1, sel_fault = 1, cap;
  logic [1:0] sel_t = 2'h3;
  logic [7:0] en = 0, clr = 8'hff, prev = 0, cur = 0, got, q[$];
  logic [15:0] tcnt = 0, exp_latch = 0;
  wire [7:0] pins, flags;
  wire [15:0] latch;
  wire irq, nmi, abort, lvl_gp, nmi_gp;
  int n_fail = 0, samples_checked = 0, n_nmi = 0, exp_nmi = 0, i;
  localparam logic [127:0] EXP = 128'h01000200040010002000480880000000;
  always #5 clk = ~clk;
  picl_pin_src SRC (.i_clk_sys(clk), .o_pins(pins));
  picl_capture DUT (.i_clk_sys(clk), .i_rst(rst), .i_rise_edge_input_a(pins[0]), .i_rise_edge_input_b(pins[1]),
    .i_fall_edge_input_a(pins[2]), .i_fall_edge_input_b(pins[3]), .i_fall_edge_input_c(pins[4]),
    .i_measure_pin(pins[5]), .i_level_req_n(pins[6]), .i_nmi_abort_n(pins[7]), .i_core_irq_disable(en[0]),
    .i_bus_ctrl_request_select(sel_req), .i_bus_ctrl_fault_enable(sel_fault), .i_timer_ctrl_edge_sel_lo(sel_t[0]),
    .i_timer_ctrl_edge_sel_hi(sel_t[1]), .i_interrupt_enable_regs(en), .i_flag_clear(clr),
    .i_measure_timer_count(tcnt), .o_interrupt_flag_regs(flags), .o_irq(irq), .o_nmi(nmi), .o_abort(abort),
    .o_level_gpio_in(lvl_gp), .o_nmi_abort_gpio_in(nmi_gp), .o_measure_timer_latch(latch));
  task check(input string name, input logic [15:0] want, input logic [15:0] act); begin
    samples_checked++;
    if (act !== want) begin n_fail++; $display("BAD %s exp %h got %h", name, want, act); end
  end endtask
  task step(input logic [7:0] ef, input logic [7:0] flip); begin
    cap = flip[5] && (pins[5] ? sel_t[1] : sel_t[0]);
    if (flip[7] && pins[7] && sel_req) exp_nmi++;
    SRC.drive(pins ^ flip);
    en = 8'($urandom);
    tcnt = 16'($urandom);
    if (cap) exp_latch = tcnt;
    if (ef !== cur) begin cur = ef; q.push_back(ef); end
    repeat (8) @(posedge clk);
    #1;
    check("irq", {15'h0, !en[0] && (cur & en) != 0}, {15'h0, irq});
    check("abort", {15'h0, sel_fault && !pins[7]}, {15'h0, abort});
    check("gpio", {14'h0, pins[7:6]}, {14'h0, nmi_gp, lvl_gp});
    check("latch", exp_latch, latch);
    if ((cur & 8'h7f) != 0) begin
      cur &= 8'h80; q.push_back(cur);
      clr = 8'hff; @(posedge clk) #1 clr = 0;
    end
    repeat (4) @(posedge clk);
  end endtask
  // Falling edge, so the one-cycle pulse has settled
  always @(negedge clk) if (nmi === 1'b1) n_nmi++;
  task print_verdict; begin
    if (q.size() != 0) n_fail++;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  end endtask
  // Falling edge, so flag updates have landed
  always @(negedge clk) if (mon && flags !== prev) begin
    prev = flags;
    got = q.size() != 0 ? q.pop_front() : 8'hxx;
    samples_checked++;
    if (got !== flags) begin n_fail++; $display("BAD flags exp %h got %h", got, flags); end
  end
  initial begin #20000 n_fail++; print_verdict; end
  initial begin
    void'($urandom(32'hd625));
    repeat (6) @(posedge clk);
    #1 rst = 0;
    // Clear held on, since idle-low pins look like edges at release
    repeat (8) @(posedge clk);
    #1 clr = 0;
    mon = 1;
    for (i = 0; i < 16; i++) step(EXP[127-8*i -: 8], 8'(8'h01 << (i / 2)));
    // Controls off: capture, level flag, nmi and abort must stay quiet
    #1 {sel_req, sel_fault, sel_t} = 4'h0;
    step(8'h40, 8'he0);
    step(8'h08, 8'he0);
    check("nmi count", exp_nmi[15:0], n_nmi[15:0]);
    print_verdict;
  end
endmodule
